/* hw/ior_pkg.sv */
// How it works
// - After reset the option word reads zero, every option Yes.
// - Each option owns one bit weight; a set bit selects No.
// - Weight 64 set stops automatic speakerphone on terminal dialing.
// - Telephone Yes: phone loss ends an active data call.
// - Telephone Yes and no telephone: refuse every data call setup.
// - Telephone bit (weight 1) takes effect only at next power-up.
// - Weight 2 selects mu-law when clear, A-law when set, immediately.
// - Weight 4 clear: phone dials audibly; set: internal dialer, silent.
// - Metering clear: adapt to remote speed, report selected speed.
// - Metering set: convert rates, report local rate, throttle CTS.
// - Metering and busyout changes apply only while idle, else at idle.
// - Weight 32 clear: speakerphone before dialing; set: after dialing.
// - Immediate setting: voice dials only, auto Yes, telephone dialing.
// - Weight 128 set: busy out line during either local loopback test.
// - Factory restore leaves the option word untouched, and vice versa.
// - Read command returns the value; write command stores a new one.
// - Automatic speakerphone does nothing without a speakerphone.
package ior_pkg;

   // ----------------------------------------------------------------------
   // Option word layout
   // ----------------------------------------------------------------------
   localparam int        IOR_WIDTH      = 8;
   localparam logic [7:0] IOR_RESET     = 8'h00;
   localparam int        IOR_BIT_PHONE  = 0;
   localparam int        IOR_BIT_COMPAND = 1;
   localparam int        IOR_BIT_DIAL   = 2;
   localparam int        IOR_BIT_SPARE  = 3;
   localparam int        IOR_BIT_METER  = 4;
   localparam int        IOR_BIT_IMMED  = 5;
   localparam int        IOR_BIT_AUTO   = 6;
   localparam int        IOR_BIT_BUSY   = 7;

   // ----------------------------------------------------------------------
   // Synchroniser depth
   // ----------------------------------------------------------------------
   localparam int        IOR_SYNC_STAGES = 2;

   // ----------------------------------------------------------------------
   // Speakerphone control states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      IOR_SPK_OFF  = 2'b00,
      IOR_SPK_WAIT = 2'b01,
      IOR_SPK_ON   = 2'b10
   } ior_spk_t;

   typedef struct packed
   {
      logic [7:0] opt;
      logic       meter;
      logic       busy;
      logic       phone_no;
      logic [7:0] rd_data;
      logic       rd_valid;
      logic       phone_prev;
      logic       teardown;
      logic       restore_ack;
      ior_spk_t   spk;
   } ior_state_t;

endpackage

/* hw/ior_sync.sv */
`timescale 1ns/1ps
module ior_sync
   import ior_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } ior_sync_t;

   ior_sync_t s;
   ior_sync_t next_s;

   // The chain below is built for exactly two stages.
   if (WIDTH < 1 || IOR_SYNC_STAGES != 2)
   begin : g_bad_config
      $error("ior_sync needs WIDTH of one or more and two stages");
   end

   // ----------------------------------------------------------------------
   // Two-stage chain; only the second stage is read outside.
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_s        = s;
      next_s.stage1 = async_in;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign sync_out = s.stage2;

endmodule

/* hw/ior_top.sv */
`timescale 1ns/1ps
module ior_top
   import ior_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Host command port
   input  wire logic       cmd_read,
   input  wire logic       cmd_write,
   input  wire logic [7:0] cmd_wdata,
   output logic      [7:0] rd_data,
   output logic            rd_valid,
   // Factory configuration restore
   input  wire logic       restore_defaults,
   output logic            restore_ack,
   // Power sequencing
   input  wire logic       power_up_load,
   // Pins from the telephone port
   input  wire logic       phone_attached,
   input  wire logic       speakerphone_present,
   // Activity from call processing
   input  wire logic       call_active,
   input  wire logic       test_mode,
   input  wire logic       loop_local,
   input  wire logic       loop_self,
   input  wire logic       local_overrun,
   // Voice dialing events
   input  wire logic       voice_dial_start,
   input  wire logic       dial_done,
   input  wire logic       voice_call_end,
   // Option effects
   output logic            a_law_select,
   output logic            internal_dialer,
   output logic            tones_audible,
   output logic            rate_adapt,
   output logic            connect_reports_local,
   output logic            cts_ready,
   output logic            line_busyout,
   output logic            call_setup_allowed,
   output logic            call_teardown,
   output logic            speakerphone_on
);

   ior_state_t s;
   ior_state_t next_s;

   logic [1:0] pins_sync;
   logic       phone_att_s;
   logic       spk_present_s;
   logic       idle;
   logic       auto_ok;
   logic       immed_ok;
   logic       loopback;

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------
   ior_sync #(
      .WIDTH    (2)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in ({speakerphone_present, phone_attached}),
      .sync_out (pins_sync)
   );

   assign phone_att_s   = pins_sync[0];
   assign spk_present_s = pins_sync[1];

   // ----------------------------------------------------------------------
   // Activity decode
   // ----------------------------------------------------------------------
   assign loopback = loop_local | loop_self;
   assign idle     = ~test_mode & ~loopback & ~call_active;

   // Immediate activation only pays off when the telephone dials, since
   // only then are there tones for the user to hear.
   assign auto_ok  = ~s.opt[IOR_BIT_AUTO] & spk_present_s;
   assign immed_ok = ~s.opt[IOR_BIT_IMMED]
                     & ~s.opt[IOR_BIT_DIAL];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_s             = s;
      next_s.rd_valid    = 1'b0;
      next_s.teardown    = 1'b0;
      next_s.restore_ack = 1'b0;

      // The whole word is stored, the spare weight 8 bit included.
      if (cmd_write)
         next_s.opt = cmd_wdata;

      // A read in the same cycle as a write returns the old value.
      if (cmd_read)
      begin
         next_s.rd_data  = s.opt;
         next_s.rd_valid = 1'b1;
      end

      // Metering and busyout follow the word only while idle, so that a
      // running call or test never sees its behaviour change under it.
      if (idle)
      begin
         next_s.meter = s.opt[IOR_BIT_METER];
         next_s.busy  = s.opt[IOR_BIT_BUSY];
      end

      // The telephone mode must match how the line is administered, so a
      // written change waits for the next power-up.
      if (power_up_load)
         next_s.phone_no = s.opt[IOR_BIT_PHONE];

      next_s.phone_prev = phone_att_s;
      if (~s.phone_no & call_active & s.phone_prev & ~phone_att_s)
         next_s.teardown = 1'b1;

      // Restoring defaults does not touch the option word.
      if (restore_defaults)
         next_s.restore_ack = 1'b1;

      case (s.spk)
         IOR_SPK_OFF:
         begin
            if (voice_dial_start & auto_ok)
            begin
               if (immed_ok)
                  next_s.spk = IOR_SPK_ON;
               else
                  next_s.spk = IOR_SPK_WAIT;
            end
         end
         IOR_SPK_WAIT:
         begin
            if (voice_call_end)
               next_s.spk = IOR_SPK_OFF;
            else if (dial_done)
               next_s.spk = IOR_SPK_ON;
         end
         IOR_SPK_ON:
         begin
            if (voice_call_end)
               next_s.spk = IOR_SPK_OFF;
         end
         default:
         begin
            next_s.spk = IOR_SPK_OFF;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s          <= '0;
         s.opt      <= IOR_RESET;
         s.spk      <= IOR_SPK_OFF;
      end
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign rd_data               = s.rd_data;
   assign rd_valid              = s.rd_valid;
   assign restore_ack           = s.restore_ack;
   assign a_law_select          = s.opt[IOR_BIT_COMPAND];
   assign internal_dialer       = s.opt[IOR_BIT_DIAL];
   assign tones_audible         = ~s.opt[IOR_BIT_DIAL];
   assign rate_adapt            = ~s.meter;
   assign connect_reports_local = s.meter;
   // CTS is only withheld during a metered call whose local side outruns
   // the remote; outside a call the terminal is never throttled.
   assign cts_ready             = ~(s.meter & call_active
                                    & local_overrun);
   assign line_busyout          = s.busy & loopback;
   assign call_setup_allowed    = s.phone_no | phone_att_s;
   assign call_teardown         = s.teardown;
   assign speakerphone_on       = (s.spk == IOR_SPK_ON);

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   // The bit positions above assume an eight-bit option word.
   if (IOR_WIDTH != 8)
   begin : g_width_check
      $error("ior_top serves only an eight-bit option word");
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking

   default disable iff (rst);

   chk_reset_zero: assert property (
      $fell(rst) |-> (s.opt == 8'h00) && !speakerphone_on
   ) else $error("option word not zero after reset");

   chk_write_store: assert property (
      cmd_write |=> (s.opt == $past(cmd_wdata))
   ) else $error("written value not stored");

   chk_read_return: assert property (
      (cmd_read && !cmd_write) ##1 !cmd_write |=>
         rd_valid == 1'b0 || rd_data == $past(s.opt, 2)
   ) else $error("read returned wrong value");

   chk_read_timing: assert property (
      cmd_read |=> rd_valid && (rd_data == $past(s.opt))
   ) else $error("read answer missing or wrong");

   chk_compand_now: assert property (
      cmd_write |=> a_law_select == $past(cmd_wdata[IOR_BIT_COMPAND])
   ) else $error("companding change not immediate");

   chk_busy_hold: assert property (
      !idle |=> $stable(s.busy) && $stable(s.meter)
   ) else $error("metering or busyout changed outside idle");

   chk_idle_apply: assert property (
      idle |=> s.meter == $past(s.opt[IOR_BIT_METER])
               && s.busy == $past(s.opt[IOR_BIT_BUSY])
   ) else $error("idle did not apply metering or busyout");

   chk_busyout_loop: assert property (
      line_busyout |-> (loop_local || loop_self) && s.busy
   ) else $error("busyout outside loopback test");

   chk_phone_hold: assert property (
      !power_up_load |=> $stable(s.phone_no)
   ) else $error("telephone mode changed without power-up");

   chk_setup_refuse: assert property (
      (!s.phone_no && !phone_att_s) |-> !call_setup_allowed
   ) else $error("data call allowed without telephone");

   chk_teardown: assert property (
      (!s.phone_no && call_active && s.phone_prev && !phone_att_s)
         |=> call_teardown
   ) else $error("data call kept after telephone loss");

   chk_restore_keep: assert property (
      (restore_defaults && !cmd_write) |=> $stable(s.opt) && restore_ack
   ) else $error("factory restore disturbed option word");

   chk_spk_gated: assert property (
      (s.spk == IOR_SPK_OFF && voice_dial_start && !auto_ok)
         |=> !speakerphone_on
   ) else $error("speakerphone activated while automatic is off");

   chk_spk_delay: assert property (
      (s.spk == IOR_SPK_OFF && voice_dial_start && auto_ok && !immed_ok)
         |=> (s.spk == IOR_SPK_WAIT) && !speakerphone_on
   ) else $error("speakerphone not delayed until dialing done");

   chk_spk_immed: assert property (
      (s.spk == IOR_SPK_OFF && voice_dial_start && auto_ok && immed_ok)
         |=> speakerphone_on
   ) else $error("speakerphone not activated before dialing");

   chk_cts_throttle: assert property (
      (s.meter && call_active && local_overrun) |-> !cts_ready
   ) else $error("CTS not withheld while metering");

   chk_cts_free: assert property (
      !call_active |-> cts_ready
   ) else $error("CTS withheld outside a data call");

   chk_meter_adapt: assert property (
      !s.meter |-> rate_adapt && !connect_reports_local
   ) else $error("unmetered call does not adapt its speed");

   chk_meter_local: assert property (
      s.meter |-> !rate_adapt && connect_reports_local
   ) else $error("metered call does not report the local rate");

   // ----------------------------------------------------------------------
   // Option word storage checks
   // ----------------------------------------------------------------------
   chk_spare_stored: assert property (
      cmd_write |=> s.opt[IOR_BIT_SPARE] == $past(cmd_wdata[IOR_BIT_SPARE])
   ) else $error("spare bit not stored as written");

   chk_dial_now: assert property (
      cmd_write |=> internal_dialer == $past(cmd_wdata[IOR_BIT_DIAL])
                    && tones_audible != internal_dialer
   ) else $error("dialing source change not immediate");

   chk_word_hold: assert property (
      !cmd_write |=> $stable(a_law_select) && $stable(internal_dialer)
   ) else $error("decoded option changed without a write");

   chk_rdata_hold: assert property (
      !cmd_read |=> $stable(rd_data) && !rd_valid
   ) else $error("read answer changed without a read");

   chk_restore_idle: assert property (
      !restore_defaults |=> !restore_ack
   ) else $error("restore answer without a request");

   // ----------------------------------------------------------------------
   // Telephone and line checks
   // ----------------------------------------------------------------------
   chk_phone_load: assert property (
      power_up_load |=> s.phone_no == $past(s.opt[IOR_BIT_PHONE])
   ) else $error("telephone mode not taken at power-up");

   chk_no_teardown: assert property (
      s.phone_no |=> !call_teardown
   ) else $error("data call torn down in data-only mode");

   chk_setup_free: assert property (
      s.phone_no |-> call_setup_allowed
   ) else $error("data call refused in data-only mode");

   chk_busy_no_loop: assert property (
      (!loop_local && !loop_self) |-> !line_busyout
   ) else $error("line busied out outside loopback test");

   chk_busy_clear: assert property (
      !s.busy |-> !line_busyout
   ) else $error("line busied out with busyout option clear");

   // ----------------------------------------------------------------------
   // Speakerphone checks
   // ----------------------------------------------------------------------
   chk_spk_wait_on: assert property (
      (s.spk == IOR_SPK_WAIT && dial_done && !voice_call_end)
         |=> speakerphone_on
   ) else $error("speakerphone not activated after dialing");

   chk_spk_end: assert property (
      (s.spk != IOR_SPK_OFF && voice_call_end) |=> !speakerphone_on
   ) else $error("speakerphone kept after the voice call");

   chk_spk_absent: assert property (
      (s.spk == IOR_SPK_OFF && !spk_present_s) |=> !speakerphone_on
   ) else $error("speakerphone activated although none is present");

endmodule

/* verification/ior_host.sv */
`timescale 1ns/1ps
module ior_host
   import ior_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Command port toward the option word
   output logic            cmd_read,
   output logic            cmd_write,
   output logic      [7:0] cmd_wdata,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   initial
   begin
      cmd_read  = 1'b0;
      cmd_write = 1'b0;
      cmd_wdata = 8'hA5;
   end
   // Data means nothing without the strobe, so it is scrambled between
   // commands rather than left looking valid.
   task automatic write_word(input logic [7:0] v);
      @(posedge clock);
      cmd_write <= 1'b1;
      cmd_wdata <= v;
      @(posedge clock);
      cmd_write <= 1'b0;
      cmd_wdata <= ~v;
   endtask
   task automatic read_word(output logic [7:0] v, output logic ok);
      @(posedge clock);
      cmd_read <= 1'b1;
      @(posedge clock);
      cmd_read <= 1'b0;
      @(negedge clock);
      ok = rd_valid;
      v  = rd_data;
   endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import ior_pkg::*;
;
   logic       clock;
   logic       rst;
   logic       cmd_read;
   logic       cmd_write;
   logic [7:0] cmd_wdata;
   logic [7:0] rd_data;
   logic       rd_valid;
   logic       restore_ack;
   logic [4:0] ev;
   logic [6:0] lv;
   logic       a_law_select;
   logic       internal_dialer;
   logic       tones_audible;
   logic       rate_adapt;
   logic       connect_reports_local;
   logic       cts_ready;
   logic       line_busyout;
   logic       call_setup_allowed;
   logic       call_teardown;
   logic       speakerphone_on;
   int         n_mismatch;
   int         tests_run;
   logic [7:0] v;
   logic       ok;
   logic       seen;
   logic [7:0] wt [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                          8'h40, 8'h80, 8'h11};
   logic [7:0] sw [5] = '{8'h00, 8'h20, 8'h40, 8'h04, 8'h00};
   logic [4:0] sx     = 5'b00001;
   logic [4:0] sy     = 5'b01011;
   // -------------------------------------------------------------------
   // Clock, device and host
   // -------------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   ior_host host (.clock(clock), .cmd_read(cmd_read), .cmd_write(cmd_write),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
   ior_top DUT (.clock(clock), .rst(rst), .cmd_read(cmd_read),
      .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
      .rd_valid(rd_valid), .restore_defaults(ev[0]),
      .restore_ack(restore_ack), .power_up_load(ev[1]),
      .phone_attached(lv[5]), .speakerphone_present(lv[6]),
      .call_active(lv[0]), .test_mode(lv[1]), .loop_local(lv[2]),
      .loop_self(lv[3]), .local_overrun(lv[4]), .voice_dial_start(ev[2]),
      .dial_done(ev[3]), .voice_call_end(ev[4]),
      .a_law_select(a_law_select), .internal_dialer(internal_dialer),
      .tones_audible(tones_audible), .rate_adapt(rate_adapt),
      .connect_reports_local(connect_reports_local),
      .cts_ready(cts_ready), .line_busyout(line_busyout),
      .call_setup_allowed(call_setup_allowed),
      .call_teardown(call_teardown), .speakerphone_on(speakerphone_on));
   task automatic chk8(input string nm, input logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge clock);
      ev <= m;
      @(posedge clock);
      ev <= 5'h00;
      @(negedge clock);
   endtask
   task automatic setlv(input int i, input logic b);
      @(posedge clock);
      lv[i] <= b;
   endtask
   task automatic endt(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #300000;
      n_mismatch++;
      complete_run();
   end
   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial
   begin
      n_mismatch = 0;
      tests_run  = 0;
      rst        = 1'b1;
      ev         = 5'h00;
      lv         = 7'b1100000;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      host.read_word(v, ok);
      chk1("rd_valid", 1'b1, ok);
      chk8("word", 8'h00, v);
      chk1("rate_adapt", 1'b1, rate_adapt);
      endt("reset");
      foreach (wt[i])
      begin
         host.write_word(wt[i]);
         cyc(2);
         host.read_word(v, ok);
         chk8("word", wt[i], v);
         chk1("a_law", wt[i][1], a_law_select);
         chk1("int_dial", wt[i][2], internal_dialer);
         chk1("tones", ~wt[i][2], tones_audible);
      end
      endt("weights");
      host.write_word(8'h55);
      pulse(5'h01);
      chk1("restore_ack", 1'b1, restore_ack);
      host.read_word(v, ok);
      chk8("word", 8'h55, v);
      endt("restore");
      host.write_word(8'h00);
      cyc(3);
      setlv(1, 1'b1);
      host.write_word(8'h90);
      cyc(3);
      chk1("rate_adapt", 1'b1, rate_adapt);
      setlv(3, 1'b1);
      cyc(1);
      chk1("busyout", 1'b0, line_busyout);
      setlv(3, 1'b0);
      setlv(1, 1'b0);
      cyc(3);
      chk1("rate_adapt", 1'b0, rate_adapt);
      chk1("rep_local", 1'b1, connect_reports_local);
      setlv(2, 1'b1);
      cyc(0);
      chk1("busyout", 1'b1, line_busyout);
      setlv(2, 1'b0);
      cyc(0);
      chk1("busyout", 1'b0, line_busyout);
      setlv(0, 1'b1);
      setlv(4, 1'b1);
      cyc(0);
      chk1("cts", 1'b0, cts_ready);
      setlv(4, 1'b0);
      setlv(0, 1'b0);
      cyc(0);
      chk1("cts", 1'b1, cts_ready);
      host.write_word(8'h00);
      cyc(3);
      endt("metering");
      setlv(5, 1'b0);
      cyc(4);
      chk1("setup", 1'b0, call_setup_allowed);
      setlv(5, 1'b1);
      setlv(0, 1'b1);
      cyc(4);
      chk1("setup", 1'b1, call_setup_allowed);
      setlv(5, 1'b0);
      seen = 1'b0;
      repeat (8)
      begin
         cyc(0);
         seen = seen | call_teardown;
      end
      chk1("teardown", 1'b1, seen);
      setlv(0, 1'b0);
      host.write_word(8'h01);
      cyc(3);
      chk1("setup", 1'b0, call_setup_allowed);
      pulse(5'h02);
      cyc(1);
      chk1("setup", 1'b1, call_setup_allowed);
      setlv(5, 1'b1);
      endt("telephone");
      foreach (sw[i])
      begin
         host.write_word(sw[i]);
         setlv(6, i != 4);
         cyc(3);
         pulse(5'h04);
         chk1("spk", sx[i], speakerphone_on);
         pulse(5'h08);
         chk1("spk", sy[i], speakerphone_on);
         pulse(5'h10);
         chk1("spk", 1'b0, speakerphone_on);
      end
      endt("speaker");
      complete_run();
   end
endmodule
